// >>> bps_gate_model.sv
// Purpose: gate drivers of the power bridge on the four outputs
// Assumes: external pull-downs hold released inputs off
// Notes: flags both switches of one leg on together
`timescale 1ns/100ps

module bps_gate_model (
    // pin side
    input wire logic [3:0] lvl,
    input wire logic [3:0] oe_n,
    // switch side
    output logic [3:0] gate,
    output logic shoot
);
    // released pins fall to the off level
    assign gate = lvl & ~oe_n;
    // legs: a over b, c over d
    assign shoot = (gate[0] & gate[1]) | (gate[2] & gate[3]);
endmodule : bps_gate_model

// >>> bps_params.svh
// Purpose: constants for the bridge pwm steering and shutdown block
// Assumes: included by bare name
// Notes: register indices are word addresses on the plain port
`ifndef BPS_PARAMS_SVH
`define BPS_PARAMS_SVH
// =====================================================================
// register map
`define BPS_ADDR_RESTART_DB 2'h0
`define BPS_ADDR_SHUT_CTL 2'h1
`define BPS_ADDR_MODE_CTL 2'h2
`define BPS_ADDR_STATUS 2'h3
`define BPS_RST_REG 8'h00
// =====================================================================
// field positions
`define BPS_RESTART_BIT 7
`define BPS_SD_STATUS_BIT 7
`define BPS_SRC_HI 6
`define BPS_SRC_LO 4
`define BPS_AC_HI 3
`define BPS_AC_LO 2
`define BPS_BD_HI 1
`define BPS_BD_LO 0
`define BPS_CFG_HI 7
`define BPS_CFG_LO 6
`define BPS_POL_AC_BIT 1
`define BPS_POL_BD_BIT 0
// =====================================================================
// timing: one instruction cycle is four oscillator periods
`define BPS_TOSC_PER_TCY 3'h4
`define BPS_DB_MAX 7'h7f
`endif

// >>> bps_pkg.sv
// Purpose: types for the bridge pwm steering and shutdown block
// Assumes: constants live in bps_params.svh
// Notes: pin vectors are ordered {d, c, b, a}
package bps_pkg;
    // =================================================================
    // output configurations
    typedef enum logic [1:0] {
        BPS_CFG_SINGLE = 2'h0,
        BPS_CFG_FWD = 2'h1,
        BPS_CFG_HALF = 2'h2,
        BPS_CFG_REV = 2'h3
    } bps_cfg_t;
    // =================================================================
    // full-bridge phase, gray coded
    typedef enum logic [1:0] {
        BPS_PH_RUN = 2'h0,
        BPS_PH_BLANK = 2'h1
    } bps_phase_t;
    // =================================================================
    // pin group
    typedef struct packed {
        logic [3:0] lvl;
        logic [3:0] oe_n;
    } bps_pins_t;
    // =================================================================
    // whole block state
    typedef struct packed {
        logic [7:0] restart_db;
        logic [7:0] shut_ctl;
        logic [7:0] mode_ctl;
        bps_cfg_t cfg_act;
        logic [1:0] pol_act;
        logic [6:0] db_act;
        bps_phase_t phase;
        logic hold;
        logic [1:0] qdiv;
        logic [6:0] dcnt;
        logic base_d;
        logic match_d;
        logic [7:0] rdata;
        bps_pins_t pins;
    } bps_state_t;
endpackage : bps_pkg

// >>> bps_steer.sv
// Purpose: steers one pwm waveform onto four bridge outputs, with
//          deadband, direction change and auto shutdown
// Assumes: base waveform and period timer events come from outside
// Notes: outputs are registered; shutdown reaches the pins one edge
//        after its cause
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`include "bps_params.svh"

module bps_steer (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // period timer and duty compare
    input wire logic pwm_base,
    input wire logic period_match,
    input wire logic period_start,
    input wire logic duty_match,
    // shutdown sources
    input wire logic comparator_1,
    input wire logic comparator_2,
    input wire logic external_interrupt_pin,
    // bridge pins
    output logic bridge_out_a,
    output logic bridge_out_b,
    output logic bridge_out_c,
    output logic bridge_out_d,
    output logic bridge_oe_a_n,
    output logic bridge_oe_b_n,
    output logic bridge_oe_c_n,
    output logic bridge_oe_d_n
);

    // =================================================================
    // state
    bps_pkg::bps_state_t s_q;
    bps_pkg::bps_state_t s_d;
    logic [2:0] src;
    logic cause;
    logic enh;
    logic full_act;
    logic sd_now;
    logic shut_now;
    logic match_rise;
    logic q_tick;
    logic base_edge;
    logic [6:0] cnt_now;
    logic db_ok;
    logic wr_shut;
    logic [3:0] act;
    bps_pkg::bps_cfg_t cfg_req;

    // =================================================================
    // next state
    always_comb begin
        s_d = s_q;
        cfg_req = bps_pkg::bps_cfg_t'(s_q.mode_ctl[`BPS_CFG_HI:`BPS_CFG_LO]);
        // oscillator/4 enable for deadband counting
        q_tick = (s_q.qdiv == 2'(`BPS_TOSC_PER_TCY - 3'h1));
        s_d.qdiv = q_tick ? 2'h0 : s_q.qdiv + 2'h1;
        // source decode
        src = s_q.shut_ctl[`BPS_SRC_HI:`BPS_SRC_LO];
        cause = (src[0] & comparator_1) | (src[1] & comparator_2)
            | (src[2] & external_interrupt_pin);
        enh = (s_q.cfg_act != bps_pkg::BPS_CFG_SINGLE);
        full_act = (s_q.cfg_act == bps_pkg::BPS_CFG_FWD)
            || (s_q.cfg_act == bps_pkg::BPS_CFG_REV);
        match_rise = period_match & ~s_q.match_d;
        s_d.match_d = period_match;
        // register writes
        wr_shut = reg_wr && (reg_addr == `BPS_ADDR_SHUT_CTL);
        if (reg_wr && (reg_addr == `BPS_ADDR_RESTART_DB)) begin
            s_d.restart_db = reg_wdata;
        end
        if (wr_shut) begin
            s_d.shut_ctl[6:0] = reg_wdata[6:0];
        end
        if (reg_wr && (reg_addr == `BPS_ADDR_MODE_CTL)) begin
            s_d.mode_ctl = reg_wdata;
        end
        // shutdown status: auto clear, then write, then set wins
        sd_now = s_q.shut_ctl[`BPS_SD_STATUS_BIT];
        if (s_q.restart_db[`BPS_RESTART_BIT] && !cause) begin
            sd_now = 1'b0;
        end
        if (wr_shut && !cause) begin
            sd_now = reg_wdata[`BPS_SD_STATUS_BIT];
        end
        if (enh && cause) begin
            sd_now = 1'b1;
        end
        s_d.shut_ctl[`BPS_SD_STATUS_BIT] = sd_now;
        // hold shutdown to the next period start
        if (period_start) begin
            s_d.hold = sd_now;
        end else if (sd_now) begin
            s_d.hold = 1'b1;
        end
        shut_now = enh && (sd_now || s_q.hold);
        // settings loaded at the period boundary
        if (period_start) begin
            s_d.cfg_act = cfg_req;
            s_d.pol_act = s_q.mode_ctl[1:0];
            s_d.db_act = s_q.restart_db[6:0];
            s_d.phase = bps_pkg::BPS_PH_RUN;
        end else if (duty_match) begin
            s_d.db_act = s_q.restart_db[6:0];
        end
        // early direction switch on the last timer tick
        if (!period_start && match_rise && full_act
            && (s_q.phase == bps_pkg::BPS_PH_RUN)
            && ((cfg_req == bps_pkg::BPS_CFG_FWD)
            || (cfg_req == bps_pkg::BPS_CFG_REV))
            && (cfg_req != s_q.cfg_act)) begin
            s_d.cfg_act = cfg_req;
            s_d.phase = bps_pkg::BPS_PH_BLANK;
        end
        // deadband counter restarts on each base edge
        base_edge = (pwm_base != s_q.base_d);
        s_d.base_d = pwm_base;
        cnt_now = base_edge ? 7'h00 : s_q.dcnt;
        s_d.dcnt = cnt_now;
        if (q_tick && (cnt_now != `BPS_DB_MAX)) begin
            s_d.dcnt = cnt_now + 7'h01;
        end
        db_ok = (cnt_now >= s_q.db_act);
        // steering, vector {d, c, b, a}
        act = 4'h0;
        case (s_q.cfg_act)
            bps_pkg::BPS_CFG_SINGLE: begin
                act[0] = pwm_base;
            end
            bps_pkg::BPS_CFG_HALF: begin
                act[0] = pwm_base & db_ok;
                act[1] = ~pwm_base & db_ok;
            end
            bps_pkg::BPS_CFG_FWD: begin
                act[0] = 1'b1;
                act[3] = pwm_base & (s_q.phase == bps_pkg::BPS_PH_RUN);
            end
            bps_pkg::BPS_CFG_REV: begin
                act[2] = 1'b1;
                act[1] = pwm_base & (s_q.phase == bps_pkg::BPS_PH_RUN);
            end
            default: begin
                act = 4'h0;
            end
        endcase
        // polarity per pair
        s_d.pins.lvl = act ^ {s_q.pol_act[`BPS_POL_BD_BIT],
            s_q.pol_act[`BPS_POL_AC_BIT], s_q.pol_act[`BPS_POL_BD_BIT],
            s_q.pol_act[`BPS_POL_AC_BIT]};
        s_d.pins.oe_n = 4'h0;
        // shutdown states per pair
        if (shut_now) begin
            s_d.pins.lvl[0] = (s_q.shut_ctl[`BPS_AC_HI:`BPS_AC_LO] == 2'h1);
            s_d.pins.lvl[2] = (s_q.shut_ctl[`BPS_AC_HI:`BPS_AC_LO] == 2'h1);
            s_d.pins.lvl[1] = (s_q.shut_ctl[`BPS_BD_HI:`BPS_BD_LO] == 2'h1);
            s_d.pins.lvl[3] = (s_q.shut_ctl[`BPS_BD_HI:`BPS_BD_LO] == 2'h1);
            s_d.pins.oe_n[0] = s_q.shut_ctl[`BPS_AC_HI];
            s_d.pins.oe_n[2] = s_q.shut_ctl[`BPS_AC_HI];
            s_d.pins.oe_n[1] = s_q.shut_ctl[`BPS_BD_HI];
            s_d.pins.oe_n[3] = s_q.shut_ctl[`BPS_BD_HI];
        end
        // read data stands for one cycle
        s_d.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `BPS_ADDR_RESTART_DB: s_d.rdata = s_q.restart_db;
                `BPS_ADDR_SHUT_CTL: s_d.rdata = s_q.shut_ctl;
                `BPS_ADDR_MODE_CTL: s_d.rdata = s_q.mode_ctl;
                `BPS_ADDR_STATUS: s_d.rdata = {3'h0, s_q.cfg_act,
                    s_q.phase == bps_pkg::BPS_PH_BLANK, s_q.hold, cause};
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    // =================================================================
    // state register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_q.restart_db <= `BPS_RST_REG;
            s_q.shut_ctl <= `BPS_RST_REG;
            s_q.mode_ctl <= `BPS_RST_REG;
            s_q.cfg_act <= bps_pkg::BPS_CFG_SINGLE;
            s_q.pol_act <= 2'h0;
            s_q.db_act <= 7'h00;
            s_q.phase <= bps_pkg::BPS_PH_RUN;
            s_q.hold <= 1'b0;
            s_q.qdiv <= 2'h0;
            s_q.dcnt <= 7'h00;
            s_q.base_d <= 1'b0;
            s_q.match_d <= 1'b0;
            s_q.rdata <= 8'h00;
            s_q.pins.lvl <= 4'h0;
            s_q.pins.oe_n <= 4'hf;
        end else begin
            s_q <= s_d;
        end
    end

    // =================================================================
    // outputs
    assign reg_rdata = s_q.rdata;
    assign bridge_out_a = s_q.pins.lvl[0];
    assign bridge_out_b = s_q.pins.lvl[1];
    assign bridge_out_c = s_q.pins.lvl[2];
    assign bridge_out_d = s_q.pins.lvl[3];
    assign bridge_oe_a_n = s_q.pins.oe_n[0];
    assign bridge_oe_b_n = s_q.pins.oe_n[1];
    assign bridge_oe_c_n = s_q.pins.oe_n[2];
    assign bridge_oe_d_n = s_q.pins.oe_n[3];

    // =================================================================
    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    property p_set_status;
        enh && cause |=> s_q.shut_ctl[7] ##1 (bridge_oe_a_n
            || bridge_out_a == (s_q.shut_ctl[3:2] == 2'h1));
    endproperty
    a_set_status: assert property (p_set_status) else $error("status not set");

    property p_forward;
        s_q.cfg_act == bps_pkg::BPS_CFG_FWD && s_q.pol_act == 2'h0
            && !shut_now |=> bridge_out_a && !bridge_out_b && !bridge_out_c;
    endproperty
    a_forward: assert property (p_forward) else $error("forward steering wrong");

    property p_reverse;
        s_q.cfg_act == bps_pkg::BPS_CFG_REV && s_q.pol_act == 2'h0
            && !shut_now |=> bridge_out_c && !bridge_out_a && !bridge_out_d;
    endproperty
    a_reverse: assert property (p_reverse) else $error("reverse steering wrong");

    property p_blank;
        s_q.phase == bps_pkg::BPS_PH_BLANK && s_q.pol_act == 2'h0
            && !shut_now |=> !bridge_out_b && !bridge_out_d;
    endproperty
    a_blank: assert property (p_blank) else $error("modulated output active");

    property p_early_switch;
        match_rise && full_act && !period_start && s_q.phase == bps_pkg::BPS_PH_RUN
            && (cfg_req == bps_pkg::BPS_CFG_FWD || cfg_req == bps_pkg::BPS_CFG_REV)
            && cfg_req != s_q.cfg_act
            |=> s_q.phase == bps_pkg::BPS_PH_BLANK && s_q.cfg_act == $past(cfg_req);
    endproperty
    a_early_switch: assert property (p_early_switch) else $error("no early switch");

    property p_write_ignored;
        cause && s_q.shut_ctl[7] && wr_shut |=> s_q.shut_ctl[7];
    endproperty
    a_write_ignored: assert property (p_write_ignored) else $error("status write taken");

    property p_auto_clear;
        s_q.restart_db[7] && !cause && !wr_shut && s_q.shut_ctl[7]
            |=> !s_q.shut_ctl[7];
    endproperty
    a_auto_clear: assert property (p_auto_clear) else $error("status not cleared");

    property p_sticky;
        !s_q.restart_db[7] && !wr_shut && s_q.shut_ctl[7] |=> s_q.shut_ctl[7];
    endproperty
    a_sticky: assert property (p_sticky) else $error("status lost");

    property p_tristate;
        shut_now && s_q.shut_ctl[3] && s_q.shut_ctl[1]
            |=> bridge_oe_a_n && bridge_oe_b_n && bridge_oe_c_n && bridge_oe_d_n;
    endproperty
    a_tristate: assert property (p_tristate) else $error("pins not released");

    property p_hold_period;
        s_q.hold && !period_start && enh |=> s_q.hold;
    endproperty
    a_hold_period: assert property (p_hold_period) else $error("hold dropped");

    // half bridge pair never on together
    property p_half_complement;
        s_q.cfg_act == bps_pkg::BPS_CFG_HALF && s_q.pol_act == 2'h0 && !shut_now
            |=> !(bridge_out_a && bridge_out_b);
    endproperty
    a_half_complement: assert property (p_half_complement) else $error("pair overlap");

    // base edge starts a dead interval
    property p_deadband_start;
        s_q.cfg_act == bps_pkg::BPS_CFG_HALF && s_q.pol_act == 2'h0 && !shut_now
            && base_edge && s_q.db_act != 7'h00 |=> !bridge_out_a && !bridge_out_b;
    endproperty
    a_deadband_start: assert property (p_deadband_start) else $error("no deadband");

    // single output mode never shuts down
    property p_single_drives;
        !enh |=> !bridge_oe_a_n && !bridge_oe_b_n && !bridge_oe_c_n && !bridge_oe_d_n;
    endproperty
    a_single_drives: assert property (p_single_drives) else $error("single mode shut");

    // driven shutdown level of pair a/c
    property p_pair_ac_level;
        shut_now && !s_q.shut_ctl[3] |=> !bridge_oe_a_n && !bridge_oe_c_n
            && bridge_out_a == $past(s_q.shut_ctl[2])
            && bridge_out_c == $past(s_q.shut_ctl[2]);
    endproperty
    a_pair_ac_level: assert property (p_pair_ac_level) else $error("a/c level wrong");

    // no source selected, no hardware set
    property p_source_off;
        enh && s_q.shut_ctl[6:4] == 3'h0 && !wr_shut && !s_q.shut_ctl[7]
            |=> !s_q.shut_ctl[7];
    endproperty
    a_source_off: assert property (p_source_off) else $error("disabled source shut");

    // read data only after a read strobe
    property p_rdata_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data stands");

endmodule : bps_steer

// >>> bps_steer_tb.sv
// Purpose: self-checking bench for bps_steer
// Assumes: gate model stands on the bridge pins
// Notes: driver queues expectations, monitor compares them
`timescale 1ns/100ps

module bps_steer_tb;
    // =========================================================
    // signals
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic pwm_base = 1'b0;
    logic period_match = 1'b0;
    logic period_start = 1'b0;
    logic duty_match = 1'b0;
    logic [2:0] src = 3'h0;
    logic [7:0] reg_rdata;
    logic [3:0] lvl;
    logic [3:0] oe_n;
    logic [3:0] gate;
    logic shoot;
    logic shoot_chk = 1'b0;
    logic rd_seen = 1'b0;
    logic [7:0] rd_q[$];
    logic [15:0] pin_q[$];
    logic [15:0] pv;
    int error_cnt = 0;
    int n_checks = 0;

    // free-running clock
    always #2.5 mclk = ~mclk;

    bps_steer u_dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_base(pwm_base),
        .period_match(period_match), .period_start(period_start), .duty_match(duty_match),
        .comparator_1(src[0]), .comparator_2(src[1]), .external_interrupt_pin(src[2]),
        .bridge_out_a(lvl[0]), .bridge_out_b(lvl[1]), .bridge_out_c(lvl[2]),
        .bridge_out_d(lvl[3]), .bridge_oe_a_n(oe_n[0]), .bridge_oe_b_n(oe_n[1]),
        .bridge_oe_c_n(oe_n[2]), .bridge_oe_d_n(oe_n[3]));
    bps_gate_model u_gate (.lvl(lvl), .oe_n(oe_n), .gate(gate), .shoot(shoot));

    // =========================================================
    // tasks
    task automatic cmp(input string what, input logic [7:0] m, input logic [7:0] e,
                       input logic [7:0] g);
        n_checks++;
        if (((g ^ e) & m) !== 8'h00) begin
            error_cnt++;
            $display("CHECK FAILED %s exp=%h got=%h", what, e, g);
        end
    endtask : cmp

    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge mclk);
        rd_q.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
    endtask : rd

    // note expected pins {oe_n, lvl} under a mask
    task automatic chk(input logic [7:0] m, input logic [7:0] e);
        @(posedge mclk);
        pin_q.push_back({m, e});
    endtask : chk

    // last timer ticks, then new period
    task automatic pend(input int n);
        @(posedge mclk) period_match <= 1'b1;
        repeat (n) @(posedge mclk);
        period_match <= 1'b0;
        period_start <= 1'b1;
        @(posedge mclk) period_start <= 1'b0;
    endtask : pend

    // =========================================================
    // monitor
    always @(posedge mclk) rd_seen <= reg_rd;

    // compare settled results at the falling edge
    always @(negedge mclk) begin
        if (rd_seen) cmp("rdata", 8'hff, rd_q.pop_front(), reg_rdata);
        if (pin_q.size() != 0) begin
            pv = pin_q.pop_front();
            cmp("pins", pv[15:8], pv[7:0], {oe_n, lvl});
        end
        if (shoot_chk) cmp("shoot", 8'h01, 8'h00, {7'h00, shoot});
    end

    // watchdog
    initial begin
        #50000;
        error_cnt++;
        print_verdict();
    end

    // =========================================================
    // main sequence
    initial begin
        int sel;
        int s;
        logic [1:0] ac;
        logic [1:0] bd;
        logic rs;
        logic hit;
        logic [7:0] v;
        logic [7:0] se;
        logic [7:0] sm;
        void'($urandom(32'h4fd281d0));
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        // register reset values and read/write
        rd(2'h0, 8'h00);
        rd(2'h1, 8'h00);
        rd(2'h2, 8'h00);
        v = 8'($urandom);
        wr(2'h0, v);
        rd(2'h0, v);
        wr(2'h2, ~v);
        rd(2'h2, ~v);
        wr(2'h1, v & 8'h7f);
        rd(2'h1, v & 8'h7f);
        wr(2'h3, 8'hff);
        rd(2'h3, 8'h00);
        wr(2'h1, 8'h00);
        // half bridge with deadband of three
        wr(2'h0, 8'h03);
        wr(2'h2, 8'h80);
        pend(1);
        cyc(20);
        chk(8'h33, 8'h02);
        @(posedge mclk) pwm_base <= 1'b1;
        cyc(6);
        chk(8'h33, 8'h00);
        cyc(10);
        chk(8'h33, 8'h01);
        // deadband longer than the pulse, loaded at duty boundary
        wr(2'h0, 8'h7f);
        @(posedge mclk) duty_match <= 1'b1;
        @(posedge mclk) duty_match <= 1'b0;
        @(posedge mclk) pwm_base <= 1'b0;
        cyc(20);
        @(posedge mclk) pwm_base <= 1'b1;
        cyc(30);
        chk(8'h33, 8'h00);
        // full bridge forward, deadband left programmed
        @(posedge mclk) pwm_base <= 1'b0;
        wr(2'h2, 8'h40);
        pend(1);
        shoot_chk <= 1'b1;
        chk(8'hff, 8'h01);
        @(posedge mclk) pwm_base <= 1'b1;
        chk(8'hff, 8'h09);
        // early reversal at the end of a full-duty period
        @(posedge mclk) pwm_base <= 1'b0;
        pend(1);
        wr(2'h2, 8'hc0);
        @(posedge mclk) pwm_base <= 1'b1;
        chk(8'hff, 8'h09);
        @(posedge mclk) period_match <= 1'b1;
        chk(8'hff, 8'h09);
        chk(8'hff, 8'h04);
        chk(8'hff, 8'h04);
        @(posedge mclk) period_match <= 1'b0;
        period_start <= 1'b1;
        @(posedge mclk) period_start <= 1'b0;
        chk(8'hff, 8'h06);
        // active low on both pairs
        shoot_chk <= 1'b0;
        @(posedge mclk) pwm_base <= 1'b0;
        wr(2'h2, 8'hc3);
        pend(2);
        chk(8'hff, 8'h0b);
        wr(2'h2, 8'h40);
        pend(2);
        chk(8'hff, 8'h01);
        // every source select against every cause
        for (sel = 0; sel < 8; sel++) begin
            for (s = 0; s < 3; s++) begin
                ac = 2'($urandom);
                bd = 2'($urandom);
                rs = 1'($urandom);
                hit = sel[s];
                se = {bd[1], ac[1], bd[1], ac[1], bd[0], ac[0], bd[0], ac[0]};
                sm = hit ? {4'hf, ~bd[1], ~ac[1], ~bd[1], ~ac[1]} : 8'hff;
                se = hit ? se : 8'h01;
                wr(2'h0, {rs, 7'h00});
                wr(2'h1, {1'b0, sel[2:0], ac, bd});
                pend(1);
                @(posedge mclk) src[s] <= 1'b1;
                chk(sm, se);
                rd(2'h1, {hit, sel[2:0], ac, bd});
                wr(2'h1, {1'b0, sel[2:0], ac, bd});
                rd(2'h1, {hit, sel[2:0], ac, bd});
                @(posedge mclk) src <= 3'h0;
                cyc(1);
                rd(2'h1, {hit & ~rs, sel[2:0], ac, bd});
                wr(2'h1, {1'b0, sel[2:0], ac, bd});
                chk(sm, se);
                pend(1);
                chk(8'hff, 8'h01);
            end
        end
        // forced shutdown by software
        wr(2'h0, 8'h00);
        wr(2'h1, 8'h80);
        chk(8'hff, 8'h00);
        rd(2'h1, 8'h80);
        wr(2'h1, 8'h00);
        pend(1);
        // no shutdown in single output mode
        wr(2'h2, 8'h00);
        pend(1);
        wr(2'h1, 8'h70);
        @(posedge mclk) src <= 3'h7;
        cyc(1);
        rd(2'h1, 8'h70);
        @(posedge mclk) src <= 3'h0;
        cyc(2);
        print_verdict();
    end
endmodule : bps_steer_tb
